// ### cpu_status_and_product_path.sv
// cpu status registers, product register, operand register and hardware stack
`timescale 1ns/100ps

// Behaviour
// - 32-bit product register captures each full product.
// - scaler passes product unshifted, left one, left four or right six.
// - scaler is combinational, adds no cycle.
// - eight entry sixteen bit stack.
// - operand register feeds multiplier, shift count and bit index.
// - program and data paths are separate.
// - state updates take one cycle.
// - status load writes, status store reads, either word.
// - reserved status positions always read as one.
// - bit force changes only the named status bit.
// - pointer write moves old pointer into backup, except status load; backup load copies.
// - pointer changed by indirect references, pointer load, modify aux and status load.
// - add carry sets else clears carry; sub borrow clears else sets.
// - with sixteen place shift, add may only set carry, subtract only clear it.
// - bit shifts, bit force and word one load update carry; reset sets it.
// - ram map select zero maps shared ram to data space; reset clears it.
// - direct address is page pointer above seven instruction bits.
// - irq disable blocks maskable interrupts only.
// - irq disable set by reset, acknowledge and maskable trap; bit force may change it.
// - status loads leave irq disable untouched.
// - overflow latch set on overflow, cleared by reset or branch, written by word zero load.
module cpu_status_and_product_path #(
	parameter int DEPTH = cpu_state_pkg::STACK_LVL
) (
	// clock, reset and enable
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// multiplier and operand register
	input  wire logic        product_capture,
	input  wire logic [31:0] product_in,
	input  wire logic        operand_load,
	input  wire logic [15:0] operand_in,
	// hardware stack
	input  wire logic        stack_push,
	input  wire logic        stack_pop,
	input  wire logic [15:0] stack_push_data,
	// status load and store
	input  wire logic        load_status_op,
	input  wire logic        store_status_op,
	input  wire logic        status_word_sel,
	input  wire logic [15:0] status_load_data,
	// single-bit force
	input  wire logic        bit_force_high_op,
	input  wire logic        bit_force_low_op,
	input  wire logic [2:0]  bit_force_sel,
	// pointer and page updates
	input  wire logic        aux_ptr_write,
	input  wire logic [2:0]  aux_ptr_value,
	input  wire logic        page_load_op,
	input  wire logic [8:0]  page_load_value,
	input  wire logic [6:0]  instr_offset,
	input  wire logic        shift_mode_load,
	input  wire logic [1:0]  shift_mode_value,
	// arithmetic unit events
	input  wire logic        add_done,
	input  wire logic        sub_done,
	input  wire logic        shift16_op,
	input  wire logic        carry_or_borrow,
	input  wire logic        shift_carry_load,
	input  wire logic        shift_carry_value,
	input  wire logic        arith_overflow,
	input  wire logic        conditional_branch_op,
	input  wire logic        test_flag_load,
	input  wire logic        test_flag_value,
	// interrupt control
	input  wire logic        irq_acknowledge,
	input  wire logic        maskable_trap_taken,
	input  wire logic        maskable_irq_pending,
	// product path outputs
	output logic      [31:0] product_result_reg,
	output logic      [31:0] product_scaled,
	output logic      [15:0] multiplier_operand_reg,
	output logic      [3:0]  dynamic_shift_count,
	output logic      [3:0]  bit_test_index,
	// stack output
	output logic      [15:0] stack_top,
	// status outputs
	output logic      [15:0] status_word_zero,
	output logic      [15:0] status_word_one,
	output logic      [15:0] store_data,
	output logic             store_valid,
	output logic      [15:0] direct_address,
	output logic      [2:0]  aux_select_ptr,
	output logic      [2:0]  aux_select_backup,
	output logic      [8:0]  page_pointer,
	output logic             carry,
	output logic             ram_map_select,
	output logic             global_irq_disable,
	output logic             arith_excess_latch,
	output logic             maskable_irq_allowed
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------

	logic       rst_meta_reg;
	logic       rst_sync_reg;
	logic       saturate_reg;
	logic       sign_ext_reg;
	logic       test_flag_reg;
	logic       ext_flag_reg;
	logic [1:0] shift_mode_reg;
	logic [15:0] stack_mem [DEPTH];

	// two flops release the reset synchronously
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------

	// bit force of either sense on the given field
	function automatic logic force_hits(input cpu_state_pkg::status_bit_t f);
		force_hits = (bit_force_high_op || bit_force_low_op) && (bit_force_sel == 3'(f));
	endfunction

	logic ld0;
	logic ld1;
	assign ld0 = load_status_op && !status_word_sel;
	assign ld1 = load_status_op && status_word_sel;

	// ----------------------------------------------------------------
	// product and operand registers
	// ----------------------------------------------------------------

	// full product held, scaled on the way out
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			product_result_reg <= cpu_state_pkg::RST_PROD;
		end else if (clk_en && product_capture) begin
			product_result_reg <= product_in;
		end
	end

	// operand register for multiply, dynamic shift and bit test
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			multiplier_operand_reg <= cpu_state_pkg::RST_WORD;
		end else if (clk_en && operand_load) begin
			multiplier_operand_reg <= operand_in;
		end
	end

	// shift count taken straight from the operand low nibble, bit index is fifteen minus it
	assign dynamic_shift_count = multiplier_operand_reg[3:0];
	assign bit_test_index      = 4'hf - multiplier_operand_reg[3:0];

	product_scaler #(
		.WIDTH (32)
	) u_scaler (
		.product (product_result_reg),
		.mode    (shift_mode_reg),
		.scaled  (product_scaled)
	);

	// ----------------------------------------------------------------
	// hardware stack
	// ----------------------------------------------------------------

	// push shifts down, pop shifts up
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_stack
			always_ff @(posedge clock or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					stack_mem[i] <= cpu_state_pkg::RST_WORD;
				end else if (clk_en && stack_push) begin
					stack_mem[i] <= (i == 0) ? stack_push_data : stack_mem[(i == 0) ? 0 : i-1];
				end else if (clk_en && stack_pop) begin
					stack_mem[i] <= stack_mem[(i == DEPTH-1) ? i : i+1];
				end
			end
		end
	endgenerate

	assign stack_top = stack_mem[0];

	// ----------------------------------------------------------------
	// auxiliary pointer and its backup
	// ----------------------------------------------------------------

	// word zero load leaves the backup alone
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			aux_select_ptr    <= cpu_state_pkg::RST_PTR;
			aux_select_backup <= cpu_state_pkg::RST_PTR;
		end else if (clk_en) begin
			if (ld1) begin
				aux_select_backup <= status_load_data[cpu_state_pkg::S1_BACKUP_LSB +: 3];
				aux_select_ptr    <= status_load_data[cpu_state_pkg::S1_BACKUP_LSB +: 3];
			end else if (ld0) begin
				aux_select_ptr <= status_load_data[cpu_state_pkg::S0_PTR_LSB +: 3];
			end else if (aux_ptr_write) begin
				aux_select_backup <= aux_select_ptr;
				aux_select_ptr    <= aux_ptr_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// page pointer and direct address
	// ----------------------------------------------------------------

	// page pointer from status word zero load or page load
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			page_pointer <= cpu_state_pkg::RST_PAGE;
		end else if (clk_en) begin
			if (ld0) begin
				page_pointer <= status_load_data[cpu_state_pkg::S0_PAGE_LSB +: 9];
			end else if (page_load_op) begin
				page_pointer <= page_load_value;
			end
		end
	end

	assign direct_address = {page_pointer, instr_offset};

	// ----------------------------------------------------------------
	// carry
	// ----------------------------------------------------------------

	// one update source per cycle, status load first
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			carry <= cpu_state_pkg::RST_CARRY;
		end else if (clk_en) begin
			if (ld1) begin
				carry <= status_load_data[cpu_state_pkg::S1_CARRY];
			end else if (force_hits(cpu_state_pkg::SEL_CARRY)) begin
				carry <= bit_force_high_op;
			end else if (shift_carry_load) begin
				carry <= shift_carry_value;
			end else if (add_done && shift16_op) begin
				if (carry_or_borrow) begin
					carry <= 1'b1;
				end
			end else if (sub_done && shift16_op) begin
				if (carry_or_borrow) begin
					carry <= 1'b0;
				end
			end else if (add_done) begin
				carry <= carry_or_borrow;
			end else if (sub_done) begin
				carry <= !carry_or_borrow;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt disable and overflow latch
	// ----------------------------------------------------------------

	// set events beat a force low; loads never touch it
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			global_irq_disable <= cpu_state_pkg::RST_IRQ_DIS;
		end else if (clk_en) begin
			if (irq_acknowledge || maskable_trap_taken) begin
				global_irq_disable <= 1'b1;
			end else if (force_hits(cpu_state_pkg::SEL_IRQ_DIS)) begin
				global_irq_disable <= bit_force_high_op;
			end
		end
	end

	// gate only the maskable request; reset and nonmaskable bypass this block
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			maskable_irq_allowed <= 1'b0;
		end else if (clk_en) begin
			maskable_irq_allowed <= maskable_irq_pending && !global_irq_disable;
		end
	end

	// sticky overflow, a new overflow beats any clear in the same cycle
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			arith_excess_latch <= cpu_state_pkg::RST_EXCESS;
		end else if (clk_en) begin
			if (arith_overflow) begin
				arith_excess_latch <= 1'b1;
			end else if (ld0) begin
				arith_excess_latch <= status_load_data[cpu_state_pkg::S0_EXCESS];
			end else if (conditional_branch_op) begin
				arith_excess_latch <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode bits
	// ----------------------------------------------------------------

	// mode and flag bits
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ram_map_select <= cpu_state_pkg::RST_RAM_MAP;
			saturate_reg   <= cpu_state_pkg::RST_SATURATE;
			sign_ext_reg   <= cpu_state_pkg::RST_SIGN_EXT;
			test_flag_reg  <= cpu_state_pkg::RST_TEST_FLAG;
			ext_flag_reg   <= cpu_state_pkg::RST_EXT_FLAG;
		end else if (clk_en) begin
			if (ld0) begin
				saturate_reg <= status_load_data[cpu_state_pkg::S0_SATURATE];
			end else if (force_hits(cpu_state_pkg::SEL_SATURATE)) begin
				saturate_reg <= bit_force_high_op;
			end
			if (ld1) begin
				ram_map_select <= status_load_data[cpu_state_pkg::S1_RAM_MAP];
				sign_ext_reg   <= status_load_data[cpu_state_pkg::S1_SIGN_EXT];
				test_flag_reg  <= status_load_data[cpu_state_pkg::S1_TEST_FLAG];
				ext_flag_reg   <= status_load_data[cpu_state_pkg::S1_EXT_FLAG];
			end else begin
				if (force_hits(cpu_state_pkg::SEL_RAM_MAP)) begin
					ram_map_select <= bit_force_high_op;
				end
				if (force_hits(cpu_state_pkg::SEL_SIGN_EXT)) begin
					sign_ext_reg <= bit_force_high_op;
				end
				if (force_hits(cpu_state_pkg::SEL_EXT_FLAG)) begin
					ext_flag_reg <= bit_force_high_op;
				end
				if (force_hits(cpu_state_pkg::SEL_TEST_FLAG)) begin
					test_flag_reg <= bit_force_high_op;
				end else if (test_flag_load) begin
					test_flag_reg <= test_flag_value;
				end
			end
		end
	end

	// product shift mode from its own load or status word one
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			shift_mode_reg <= cpu_state_pkg::RST_SHIFT;
		end else if (clk_en) begin
			if (ld1) begin
				shift_mode_reg <= status_load_data[cpu_state_pkg::S1_SHIFT_LSB +: 2];
			end else if (shift_mode_load) begin
				shift_mode_reg <= shift_mode_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// status words and store path
	// ----------------------------------------------------------------

	// packed views of the flops, reserved positions tied high
	always_comb begin
		status_word_zero = {aux_select_ptr, arith_excess_latch, saturate_reg, 1'b1,
		                    global_irq_disable, page_pointer};
		status_word_one  = {aux_select_backup, ram_map_select, test_flag_reg, sign_ext_reg,
		                    carry, 4'hf, ext_flag_reg, 2'h3, shift_mode_reg};
	end

	// store copies the chosen word one cycle after the request
	always_ff @(posedge clock or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			store_data  <= cpu_state_pkg::RST_WORD;
			store_valid <= 1'b0;
		end else if (clk_en) begin
			store_valid <= store_status_op;
			if (store_status_op) begin
				store_data <= status_word_sel ? status_word_one : status_word_zero;
			end
		end
	end

endmodule // cpu_status_and_product_path

// ### cpu_state_pkg.sv
// shared constants for the cpu status and product path
package cpu_state_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W    = 16;
	localparam int PROD_W    = 32;
	localparam int PTR_W     = 3;
	localparam int PAGE_W    = 9;
	localparam int OFFS_W    = 7;
	localparam int STACK_LVL = 8;

	// ----------------------------------------------------------------
	// status word zero field positions
	// ----------------------------------------------------------------
	localparam int S0_PTR_LSB  = 13;
	localparam int S0_EXCESS   = 12;
	localparam int S0_SATURATE = 11;
	localparam int S0_RSVD     = 10;
	localparam int S0_IRQ_DIS  = 9;
	localparam int S0_PAGE_LSB = 0;

	// ----------------------------------------------------------------
	// status word one field positions
	// ----------------------------------------------------------------
	localparam int S1_BACKUP_LSB = 13;
	localparam int S1_RAM_MAP    = 12;
	localparam int S1_TEST_FLAG  = 11;
	localparam int S1_SIGN_EXT   = 10;
	localparam int S1_CARRY      = 9;
	localparam int S1_RSVD_HI    = 5;
	localparam int S1_EXT_FLAG   = 4;
	localparam int S1_RSVD_LO    = 2;
	localparam int S1_SHIFT_LSB  = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [PTR_W-1:0]  RST_PTR       = 3'h0;
	localparam logic [PAGE_W-1:0] RST_PAGE      = 9'h000;
	localparam logic              RST_CARRY     = 1'b1;
	localparam logic              RST_RAM_MAP   = 1'b0;
	localparam logic              RST_IRQ_DIS   = 1'b1;
	localparam logic              RST_EXCESS    = 1'b0;
	localparam logic              RST_SATURATE  = 1'b0;
	localparam logic              RST_SIGN_EXT  = 1'b1;
	localparam logic              RST_TEST_FLAG = 1'b0;
	localparam logic              RST_EXT_FLAG  = 1'b1;
	localparam logic [1:0]        RST_SHIFT     = 2'h0;
	localparam logic [DATA_W-1:0] RST_WORD      = 16'h0000;
	localparam logic [PROD_W-1:0] RST_PROD      = 32'h0000_0000;

	// ----------------------------------------------------------------
	// product shift modes and single-bit selects
	// ----------------------------------------------------------------
	localparam logic [1:0] SHIFT_NONE   = 2'h0;
	localparam logic [1:0] SHIFT_LEFT1  = 2'h1;
	localparam logic [1:0] SHIFT_LEFT4  = 2'h2;
	localparam logic [1:0] SHIFT_RIGHT6 = 2'h3;

	typedef enum logic [2:0] {
		SEL_CARRY,
		SEL_RAM_MAP,
		SEL_IRQ_DIS,
		SEL_SATURATE,
		SEL_SIGN_EXT,
		SEL_TEST_FLAG,
		SEL_EXT_FLAG
	} status_bit_t;

endpackage

// ### product_scaler.sv
// combinational product scaling shifter
`timescale 1ns/100ps

module product_scaler #(
	parameter int WIDTH = cpu_state_pkg::PROD_W
) (
	// product in and shift mode
	input  wire logic [WIDTH-1:0] product,
	input  wire logic [1:0]       mode,
	// scaled product out
	output logic      [WIDTH-1:0] scaled
);

	// pure mux of shifts, no storage so no cycle is added
	always_comb begin
		unique case (mode)
			cpu_state_pkg::SHIFT_NONE:   scaled = product;
			cpu_state_pkg::SHIFT_LEFT1:  scaled = {product[WIDTH-2:0], 1'b0};
			cpu_state_pkg::SHIFT_LEFT4:  scaled = {product[WIDTH-5:0], 4'h0};
			cpu_state_pkg::SHIFT_RIGHT6: scaled = {{6{product[WIDTH-1]}}, product[WIDTH-1:6]};
		endcase
	end

endmodule // product_scaler

// ### decoder_model.sv
// instruction decoder model that issues one-cycle control pulses
`timescale 1ns/100ps

module decoder_model (
	// clock
	input  wire logic clock,
	// pulse controls
	output logic      product_capture, operand_load, stack_push, stack_pop,
	output logic      load_status_op, store_status_op, bit_force_high_op,
	output logic      bit_force_low_op, aux_ptr_write, page_load_op,
	output logic      shift_mode_load, add_done, sub_done, arith_overflow,
	output logic      conditional_branch_op, irq_acknowledge,
	output logic      maskable_trap_taken, shift_carry_load,
	// levels and fields
	output logic      clk_en, maskable_irq_pending, test_flag_load,
	output logic      test_flag_value, status_word_sel, shift16_op,
	output logic      carry_or_borrow, shift_carry_value,
	output logic [31:0] product_in,
	output logic [15:0] operand_in, stack_push_data, status_load_data,
	output logic [8:0]  page_load_value,
	output logic [6:0]  instr_offset,
	output logic [2:0]  bit_force_sel, aux_ptr_value,
	output logic [1:0]  shift_mode_value
);
	// ---------------------------------------------------------------
	// idle state
	// ---------------------------------------------------------------
	logic [17:0] pl;
	assign {product_capture, operand_load, stack_push, stack_pop, load_status_op,
		store_status_op, bit_force_high_op, bit_force_low_op, aux_ptr_write,
		page_load_op, shift_mode_load, add_done, sub_done, arith_overflow,
		conditional_branch_op, irq_acknowledge, maskable_trap_taken, shift_carry_load} = pl;
	initial begin
		pl = 18'h0;
		{test_flag_load, test_flag_value} = 2'h0;
		clk_en = 1'b1;
		maskable_irq_pending = 1'b1;
	end

	// ---------------------------------------------------------------
	// one instruction, pulses stand one cycle
	// ---------------------------------------------------------------
	task automatic issue(input logic [17:0] pulses, input logic [31:0] v);
		@(posedge clock);
		pl <= pulses;
		product_in <= v;
		{operand_in, stack_push_data, status_load_data} <= {3{v[15:0]}};
		page_load_value <= v[8:0];
		aux_ptr_value <= v[2:0];
		shift_mode_value <= v[1:0];
		{carry_or_borrow, shift_carry_value} <= {2{v[0]}};
		status_word_sel <= v[16];
		shift16_op <= v[17];
		bit_force_sel <= v[20:18];
		instr_offset <= v[30:24];
		@(posedge clock);
		pl <= 18'h0;
	endtask
endmodule // decoder_model

// ### cpu_status_and_product_path_sva.sv
// checker for the cpu status and product path
`timescale 1ns/100ps

module status_path_checker (
	// watched inputs
	input wire logic        clock, arst_n, clk_en, product_capture, aux_ptr_write,
	input wire logic        page_load_op, load_status_op, store_status_op, status_word_sel,
	input wire logic        bit_force_high_op, bit_force_low_op, shift_carry_load,
	input wire logic        add_done, sub_done, shift16_op, carry_or_borrow,
	input wire logic        arith_overflow, irq_acknowledge, maskable_trap_taken,
	input wire logic [31:0] product_in, product_result_reg, product_scaled,
	input wire logic [15:0] multiplier_operand_reg, status_word_zero, status_word_one,
	input wire logic [15:0] store_data, direct_address,
	input wire logic [2:0]  aux_ptr_value, aux_select_ptr, aux_select_backup,
	input wire logic [8:0]  page_load_value, page_pointer,
	input wire logic [6:0]  instr_offset,
	input wire logic [3:0]  bit_test_index,
	input wire logic        store_valid, carry, global_irq_disable, arith_excess_latch
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	logic quiet;
	assign quiet = clk_en && !load_status_op && !bit_force_high_op && !bit_force_low_op
		&& !shift_carry_load;

	sequence store_req;
		clk_en && store_status_op;
	endsequence
	sequence store_ans;
		store_valid ##1 !store_valid;
	endsequence

	rsvd_ones_a: assert property (status_word_zero[10] && status_word_one[8:5] == 4'hf
		&& status_word_one[3:2] == 2'h3) else $error("reserved status bit not one");
	scale_mode_a: assert property (product_scaled == (status_word_one[1:0] == 2'h0 ?
		product_result_reg : status_word_one[1:0] == 2'h1 ? product_result_reg << 1 :
		status_word_one[1:0] == 2'h2 ? product_result_reg << 4 :
		32'($signed(product_result_reg) >>> 6))) else $error("scaled product wrong");
	prod_take_a: assert property (clk_en && product_capture |=>
		product_result_reg == $past(product_in)) else $error("product not captured");
	page_addr_a: assert property (clk_en && page_load_op && !load_status_op |=>
		direct_address == {$past(page_load_value), instr_offset}) else $error("bad address");
	ptr_backup_a: assert property (clk_en && aux_ptr_write && !load_status_op |=>
		aux_select_ptr == $past(aux_ptr_value) && aux_select_backup == $past(aux_select_ptr))
		else $error("pointer backup wrong");
	irq_keep_a: assert property (clk_en && load_status_op && !irq_acknowledge
		&& !maskable_trap_taken && !bit_force_high_op && !bit_force_low_op
		|=> $stable(global_irq_disable)) else $error("irq bit moved");
	irq_set_a: assert property (clk_en && (irq_acknowledge || maskable_trap_taken)
		|=> global_irq_disable) else $error("irq disable not set");
	excess_set_a: assert property (clk_en && arith_overflow |=> arith_excess_latch)
		else $error("overflow not latched");
	store_word_a: assert property (store_req |=> store_ans and store_data ==
		($past(status_word_sel) ? $past(status_word_one) : $past(status_word_zero)))
		else $error("stored word wrong");
	carry_add_a: assert property (quiet && add_done && !sub_done && !shift16_op |=>
		carry == $past(carry_or_borrow)) else $error("add carry wrong");
	carry_keep_a: assert property (quiet && sub_done && !add_done && shift16_op
		&& !carry_or_borrow |=> $stable(carry)) else $error("shifted sub moved carry");
	bit_index_a: assert property (bit_test_index == 4'hf - multiplier_operand_reg[3:0])
		else $error("bit index wrong");
endmodule // status_path_checker

bind cpu_status_and_product_path status_path_checker i_status_path_checker (.*);

// ### cpu_status_and_product_path_tb.sv
// self-checking testbench for the cpu status and product path
`timescale 1ns/100ps

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module cpu_status_and_product_path_tb;
	// pulse bit positions inside the decoder word
	localparam int PROD = 17, OPND = 16, PUSH = 15, POP = 14, LD = 13, ST = 12, HI = 11;
	localparam int LO = 10, PTR = 9, PAGE = 8, MODE = 7, ADD = 6, SUB = 5, OVF = 4;
	localparam int BR = 3, ACK = 2, TRAP = 1, SHC = 0;
	logic clock = 1'b0, arst_n = 1'b0;
	logic product_capture, operand_load, stack_push, stack_pop, load_status_op;
	logic store_status_op, bit_force_high_op, bit_force_low_op, aux_ptr_write;
	logic page_load_op, shift_mode_load, add_done, sub_done, arith_overflow;
	logic conditional_branch_op, irq_acknowledge, maskable_trap_taken, shift_carry_load;
	logic clk_en, maskable_irq_pending, test_flag_load, test_flag_value, status_word_sel;
	logic shift16_op, carry_or_borrow, shift_carry_value, store_valid, carry;
	logic ram_map_select, global_irq_disable, arith_excess_latch, maskable_irq_allowed;
	logic [31:0] product_in, product_result_reg, product_scaled;
	logic [15:0] operand_in, stack_push_data, status_load_data, multiplier_operand_reg;
	logic [15:0] stack_top, status_word_zero, status_word_one, store_data, direct_address;
	logic [8:0]  page_load_value, page_pointer;
	logic [6:0]  instr_offset;
	logic [3:0]  dynamic_shift_count, bit_test_index;
	logic [2:0]  bit_force_sel, aux_ptr_value, aux_select_ptr, aux_select_backup;
	logic [1:0]  shift_mode_value;
	int fails = 0, checks_done = 0, cycles = 0;
	logic [31:0] want [4] = '{32'h8000_0123, 32'h0000_0246, 32'h0000_1230, 32'hfe00_0004};

	decoder_model i_decoder_model (.*);
	cpu_status_and_product_path i_cpu_status_and_product_path (.*);

	// ---------------------------------------------------------------
	// clock, timeout and closing report
	// ---------------------------------------------------------------
	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one instruction, then let the taking edge settle
	task automatic op(input int k, input logic [31:0] v);
		i_decoder_model.issue(18'h1 << k, v);
		#1;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_product();
		op(PROD, 32'h8000_0123);
		`CHK("product", 32'h8000_0123, product_result_reg)
		for (int m = 0; m < 4; m++) begin
			op(MODE, m);
			`CHK("scaled", want[m], product_scaled)
		end
		op(OPND, 32'h00a7);
		`CHK("shift count", 4'h7, dynamic_shift_count)
		`CHK("bit index", 4'h8, bit_test_index)
		for (int i = 1; i < 4; i++) op(PUSH, 16'h1111 * i);
		`CHK("stack top", 16'h3333, stack_top)
		op(POP, 0);
		`CHK("after pop", 16'h2222, stack_top)
		$display("product test done");
	endtask
	task automatic t_status();
		op(PTR, 5);
		op(PTR, 3);
		`CHK("backup", 3'h5, aux_select_backup)
		op(LD, 32'h0001_c000);
		`CHK("ptr copy", 3'h6, aux_select_ptr)
		`CHK("word one", 16'hc1ec, status_word_one)
		`CHK("carry load", 1'b0, carry)
		op(LD, 32'h2a00_41a5);
		`CHK("backup kept", 3'h6, aux_select_backup)
		`CHK("word zero", 16'h47a5, status_word_zero)
		`CHK("direct addr", 16'hd2aa, direct_address)
		op(ST, 0);
		`CHK("store", 16'h47a5, store_data)
		op(PAGE, 9'h0ff);
		`CHK("page", 9'h0ff, page_pointer)
		$display("status test done");
	endtask
	task automatic t_flags();
		op(SUB, 0);
		`CHK("sub carry", 1'b1, carry)
		op(ADD, 0);
		`CHK("add carry", 1'b0, carry)
		op(ADD, 32'h0002_0001);
		`CHK("add16 set", 1'b1, carry)
		op(SUB, 32'h0002_0000);
		`CHK("sub16 keep", 1'b1, carry)
		op(LO, 32'h0000_0000);
		op(SHC, 1);
		`CHK("shift carry", 1'b1, carry)
		op(LO, 32'h0008_0000);
		`CHK("word zero", 16'h44ff, status_word_zero)
		@(posedge clock);
		#1;
		`CHK("irq allowed", 1'b1, maskable_irq_allowed)
		op(ACK, 0);
		`CHK("ack sets", 1'b1, global_irq_disable)
		op(LO, 32'h0008_0000);
		op(TRAP, 0);
		`CHK("trap sets", 1'b1, global_irq_disable)
		op(HI, 32'h0004_0000);
		`CHK("ram map", 1'b1, ram_map_select)
		op(OVF, 0);
		`CHK("overflow", 1'b1, arith_excess_latch)
		op(BR, 0);
		`CHK("branch clear", 1'b0, arith_excess_latch)
		$display("flag test done");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		`CHK("reset word0", 16'h0600, status_word_zero)
		`CHK("reset word1", 16'h07fc, status_word_one)
		`CHK("reset ram map", 1'b0, ram_map_select)
		`CHK("blocked", 1'b0, maskable_irq_allowed)
		t_product();
		t_status();
		t_flags();
		wrap_up();
	end
endmodule // cpu_status_and_product_path_tb
